// [accel_detect_map.svh]
// Register offsets, reset values, field positions and timing counts of the free-fall and motion detector.
`ifndef ACCEL_DETECT_MAP_SVH
`define ACCEL_DETECT_MAP_SVH

// ****************************************
// Register map
// ****************************************
`define FALL_THRESHOLD_OFFS     7'h08
`define FALL_DEBOUNCE_OFFS      7'h09
`define MOTION_THRESHOLD_OFFS   7'h0a
`define MOTION_DEBOUNCE_OFFS    7'h0b
`define STATUS_OFFS             7'h0e
`define CONTROL_B_OFFS          7'h0d
`define CONTROL_C_OFFS          7'h0c
`define SPI_READ_BIT            7

// ****************************************
// Reset values
// ****************************************
`define FALL_THRESHOLD_RST      8'h0e
`define FALL_DEBOUNCE_RST       8'h01
`define MOTION_THRESHOLD_RST    8'h55
`define MOTION_DEBOUNCE_RST     8'h01
`define CONTROL_B_RST           8'h42
`define CONTROL_C_RST           8'h00

// ****************************************
// Field positions
// ****************************************
`define STAT_FALL_BIT           0
`define STAT_MOTION_BIT         1
`define CTLB_FALL_EN_BIT        1
`define CTLC_RATE_LO_BIT        0
`define CTLC_RATE_HI_BIT        1
`define CTLC_MOTION_LATCH_BIT   3
`define CTLC_FALL_LATCH_BIT     4
`define SAMPLE_MSB              11
`define SAMPLE_LSB              4

// ****************************************
// Timing
// ****************************************
`define REF_CLK_HZ              200000000
`define RATE_250_HZ             250
`define RATE_1K_HZ              1000
`define RATE_4K_HZ              4000
`define RATE_16K_HZ             16000
`define TICK_CNT_W              20

`endif

// [accel_detect_pkg.sv]
// Types shared by the free-fall and motion detector.
package accel_detect_pkg;

   typedef logic [11:0] sample_t;

   typedef struct packed {
      sample_t x;
      sample_t y;
      sample_t z;
   } axes_s;

   typedef struct packed {
      logic       writeStrobe;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_wr_s;

   typedef enum logic [1:0] {
      RATE_250 = 2'b00,
      RATE_1K  = 2'b01,
      RATE_4K  = 2'b10,
      RATE_16K = 2'b11
   } rate_e;

endpackage

// [accel_freefall_motion_detect.sv]
// Free-fall and motion threshold, debounce and interrupt logic with its register file.
`timescale 1ns/1ps
`include "accel_detect_map.svh"

// Contract
// R01: Free-fall needs all three axes below threshold together for the programmed delay.
// R02: Motion needs any one axis above threshold continuously for the programmed delay.
// R03: Free-fall and motion both drive the single interrupt output pin.
// R04: Thresholds are 8-bit; one step equals sixteen axis counts.
// R05: Free-fall delay register holds an 8-bit sample count.
// R06: Delay counts 0 to 255 are samples at the selected interrupt rate.
// R07: Free-fall threshold is read/write, resets to 0x0e.
// R08: Free-fall delay is read/write, resets to one.
// R09: Motion threshold is read/write, resets to 0x55.
// R10: Motion delay is read/write, resets to one.
// R11: SPI reads use address bit 7 set, writes use it clear.
// R12: Host enables an interrupt only while no trigger condition is present.
// R13: Rate bits select 250 Hz, 1 kHz, 4 kHz or 16 kHz sampling.
// R14: With free-fall enable low no free-fall interrupt is generated.
// R15: Status bits mirror the interrupt levels; writing 0 clears each.
// R16: Unlatched output follows detection; latched holds until enable cycles low. Motion has no enable here; only a status clear releases its latch.
// R17: Upper eight bits of each 12-bit sample are compared once per tick.
// R18: Debounce counter restarts on any non-qualifying sample.
module accel_freefall_motion_detect
   import accel_detect_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire axes_s       axes,
   input  wire reg_wr_s     regWr,
   input  wire logic [7:0]  regAddr,
   output logic      [7:0]  regRdata,
   output logic             intOut,
   output logic             fallIrqStatus,
   output logic             motionIrqStatus
);

   // ****************************************
   // Rate divider constants
   // ****************************************
   localparam logic [`TICK_CNT_W-1:0] DIV_250 = `TICK_CNT_W'(`REF_CLK_HZ / `RATE_250_HZ - 1);
   localparam logic [`TICK_CNT_W-1:0] DIV_1K  = `TICK_CNT_W'(`REF_CLK_HZ / `RATE_1K_HZ - 1);
   localparam logic [`TICK_CNT_W-1:0] DIV_4K  = `TICK_CNT_W'(`REF_CLK_HZ / `RATE_4K_HZ - 1);
   localparam logic [`TICK_CNT_W-1:0] DIV_16K = `TICK_CNT_W'(`REF_CLK_HZ / `RATE_16K_HZ - 1);

   typedef struct packed {
      logic [7:0]             fallThreshold;
      logic [7:0]             fallDebounce;
      logic [7:0]             motionThreshold;
      logic [7:0]             motionDebounce;
      logic [7:0]             controlB;
      logic [7:0]             controlC;
      logic [`TICK_CNT_W-1:0] tickCnt;
      logic [7:0]             fallCnt;
      logic [7:0]             motionCnt;
      logic                   fallFlag;
      logic                   motionFlag;
      logic [7:0]             rdata;
      axes_s                  axesMeta;
      axes_s                  axesSync;
   } state_s;

   state_s st;
   state_s next_st;

   logic [`TICK_CNT_W-1:0] divLimit;
   logic                   tick;
   logic                   allBelow;
   logic                   anyAbove;
   logic                   fallDetect;
   logic                   motionDetect;
   logic [6:0]             baseAddr;
   logic                   isRead;

   // Upper byte of a 12-bit sample matches the threshold scale of 16 counts a step.
   function automatic logic [7:0] upperByte(input sample_t s);
      return s[`SAMPLE_MSB:`SAMPLE_LSB]; // R04 R17
   endfunction

   // Free-fall wants every axis under its threshold in the same sample.
   function automatic logic allUnder(input axes_s a, input logic [7:0] thr);
      return (upperByte(a.x) < thr) && (upperByte(a.y) < thr) && (upperByte(a.z) < thr);
   endfunction

   // Motion wants any one axis over its threshold; a sample equal to it does not count.
   function automatic logic anyOver(input axes_s a, input logic [7:0] thr);
      return (upperByte(a.x) > thr) || (upperByte(a.y) > thr) || (upperByte(a.z) > thr);
   endfunction

   function automatic logic [`TICK_CNT_W-1:0] rateDivider(input rate_e r);
      unique case (r) // R13
         RATE_250: return DIV_250;
         RATE_1K:  return DIV_1K;
         RATE_4K:  return DIV_4K;
         RATE_16K: return DIV_16K;
      endcase
   endfunction

   // Register write decode; returns the new value when the address hits.
   function automatic logic [7:0] regUpdate(input logic [7:0] cur, input logic [6:0] offs, input reg_wr_s w);
      if (w.writeStrobe && w.addr == offs) begin
         return w.wdata;
      end
      return cur;
   endfunction

   // A status write clears a flag only where its bit is written as 0.
   function automatic logic statusClear(input reg_wr_s w, input int pos);
      return w.writeStrobe && w.addr == `STATUS_OFFS && !w.wdata[pos];
   endfunction

   // ****************************************
   // Combinational next state
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.axesMeta = axes;
      next_st.axesSync = st.axesMeta;

      // ****************************************
      // Sample tick
      // ****************************************
      // A rate change lands mid-count: a count already past the new limit ticks at once.
      divLimit = rateDivider(rate_e'({st.controlC[`CTLC_RATE_HI_BIT], st.controlC[`CTLC_RATE_LO_BIT]}));
      tick = (st.tickCnt >= divLimit);
      next_st.tickCnt = tick ? '0 : st.tickCnt + 1'b1;

      // ****************************************
      // Threshold and debounce
      // ****************************************
      allBelow = allUnder(st.axesSync, st.fallThreshold); // R01
      anyAbove = anyOver(st.axesSync, st.motionThreshold); // R02

      // Counters saturate at the programmed delay; a count of 0 qualifies on the first good sample.
      fallDetect   = allBelow && (st.fallCnt >= st.fallDebounce); // R05 R06
      motionDetect = anyAbove && (st.motionCnt >= st.motionDebounce); // R06
      if (tick) begin
         if (!allBelow) begin
            next_st.fallCnt = '0; // R18
         end else if (st.fallCnt < st.fallDebounce) begin
            next_st.fallCnt = st.fallCnt + 8'h01;
         end
         if (!anyAbove) begin
            next_st.motionCnt = '0; // R18
         end else if (st.motionCnt < st.motionDebounce) begin
            next_st.motionCnt = st.motionCnt + 8'h01;
         end
      end

      // ****************************************
      // Register file
      // ****************************************
      baseAddr = regAddr[6:0];
      isRead   = regAddr[`SPI_READ_BIT]; // R11
      next_st.fallThreshold   = regUpdate(st.fallThreshold, `FALL_THRESHOLD_OFFS, regWr); // R07
      next_st.fallDebounce    = regUpdate(st.fallDebounce, `FALL_DEBOUNCE_OFFS, regWr); // R08
      next_st.motionThreshold = regUpdate(st.motionThreshold, `MOTION_THRESHOLD_OFFS, regWr); // R09
      next_st.motionDebounce  = regUpdate(st.motionDebounce, `MOTION_DEBOUNCE_OFFS, regWr); // R10
      next_st.controlB        = regUpdate(st.controlB, `CONTROL_B_OFFS, regWr);
      next_st.controlC        = regUpdate(st.controlC, `CONTROL_C_OFFS, regWr);

      // ****************************************
      // Interrupt flags
      // ****************************************
      // Free-fall flag: a fresh detection wins over a status clear in the same cycle.
      if (!st.controlB[`CTLB_FALL_EN_BIT]) begin
         next_st.fallFlag = 1'b0; // R14 R16
      end else if (tick && fallDetect) begin
         next_st.fallFlag = 1'b1; // R01
      end else if (statusClear(regWr, `STAT_FALL_BIT)) begin
         next_st.fallFlag = 1'b0; // R15
      end else if (tick && !st.controlC[`CTLC_FALL_LATCH_BIT]) begin
         next_st.fallFlag = fallDetect; // R16
      end

      // Motion latch holds until the external motion enable is cycled; here a status clear releases it.
      if (tick && motionDetect) begin
         next_st.motionFlag = 1'b1; // R02
      end else if (statusClear(regWr, `STAT_MOTION_BIT)) begin
         next_st.motionFlag = 1'b0; // R15
      end else if (tick && !st.controlC[`CTLC_MOTION_LATCH_BIT]) begin
         next_st.motionFlag = motionDetect;
      end

      // ****************************************
      // Read port
      // ****************************************
      next_st.rdata = 8'h00;
      if (isRead) begin
         unique case (baseAddr)
            `FALL_THRESHOLD_OFFS:   next_st.rdata = st.fallThreshold;
            `FALL_DEBOUNCE_OFFS:    next_st.rdata = st.fallDebounce;
            `MOTION_THRESHOLD_OFFS: next_st.rdata = st.motionThreshold;
            `MOTION_DEBOUNCE_OFFS:  next_st.rdata = st.motionDebounce;
            `CONTROL_B_OFFS:        next_st.rdata = st.controlB;
            `CONTROL_C_OFFS:        next_st.rdata = st.controlC;
            `STATUS_OFFS:           next_st.rdata = {6'h00, st.motionFlag, st.fallFlag}; // R15
            default:                next_st.rdata = 8'h00;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st                 <= '0;
         st.fallThreshold   <= `FALL_THRESHOLD_RST;
         st.fallDebounce    <= `FALL_DEBOUNCE_RST;
         st.motionThreshold <= `MOTION_THRESHOLD_RST;
         st.motionDebounce  <= `MOTION_DEBOUNCE_RST;
         st.controlB        <= `CONTROL_B_RST;
         st.controlC        <= `CONTROL_C_RST;
      end else begin
         st <= next_st;
      end
   end

   assign regRdata        = st.rdata;
   assign intOut          = st.fallFlag | st.motionFlag; // R03
   assign fallIrqStatus   = st.fallFlag;
   assign motionIrqStatus = st.motionFlag;

endmodule

// [accel_detect_properties.sv]
// Port-level assertions for the free-fall and motion detector.
`timescale 1ns/1ps
module accel_detect_properties
   import accel_detect_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst_b,
   input wire axes_s      axes,
   input wire reg_wr_s    regWr,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regRdata,
   input wire logic       intOut,
   input wire logic       fallIrqStatus,
   input wire logic       motionIrqStatus
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic fallEn;
   // Shadow of the free-fall enable, so the disabled state can be judged at the ports.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fallEn <= 1'b1;
      end else if (regWr.writeStrobe && regWr.addr == 7'h0d) begin
         fallEn <= regWr.wdata[1];
      end
   end
   a_int_has_cause:
   assert property (intOut |-> fallIrqStatus || motionIrqStatus || $past(fallIrqStatus) || $past(motionIrqStatus))
      else $error("interrupt pin high with no flag");
   a_int_follows_flag:
   assert property ((fallIrqStatus || motionIrqStatus) |-> ##[0:1] intOut) else $error("flag not on pin");
   a_read_low_half:
   assert property (!regAddr[7] |=> regRdata == 8'h00) else $error("read without bit 7 returned data");
   a_read_unmapped:
   assert property (regAddr > 8'h8e |=> regRdata == 8'h00) else $error("unmapped read returned data");
   a_status_read:
   assert property (regAddr == 8'h8e |=> regRdata == {6'h00, $past(motionIrqStatus), $past(fallIrqStatus)})
      else $error("status read differs from flags");
   a_write_readback:
   assert property ((regWr.writeStrobe && regWr.addr inside {[7'h08:7'h0b]}) ##1
      (!regWr.writeStrobe && regAddr == {1'b1, $past(regWr.addr)}) |=> regRdata == $past(regWr.wdata, 2))
      else $error("threshold or delay readback wrong");
   a_fall_clear:
   assert property (regWr.writeStrobe && regWr.addr == 7'h0e && !regWr.wdata[0] |=> !fallIrqStatus)
      else $error("free-fall flag not cleared");
   a_motion_clear:
   assert property (regWr.writeStrobe && regWr.addr == 7'h0e && !regWr.wdata[1] |=> !motionIrqStatus)
      else $error("motion flag not cleared");
   a_fall_disabled:
   assert property (!fallEn |=> !fallIrqStatus) else $error("free-fall flag while disabled");
endmodule

// [accel_host_model.sv]
// Host that reaches the detector's registers directly through its write struct and read address ports.
`timescale 1ns/1ps
module accel_host_model
   import accel_detect_pkg::*;
(
   input  wire logic [7:0] regRdata,
   input  wire logic       ref_clk,
   output reg_wr_s         regWr,
   output logic [7:0]      regAddr
);
   initial begin
      regWr   = '0;
      regAddr = 8'h00;
   end
   // Leaves the read address on the written register, so the readback is visible at once.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWr <= '{writeStrobe: 1'b1, addr: a, wdata: d};
      @(posedge ref_clk);
      regWr   <= '0;
      regAddr <= {1'b1, a};
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      @(posedge ref_clk);
      @(posedge ref_clk);
      d = regRdata;
   endtask
endmodule

// [accel_freefall_motion_detect_tb_top.sv]
// Self-checking bench for the free-fall and motion detector.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module accel_freefall_motion_detect_tb_top
   import accel_detect_pkg::*;
;
   localparam int TICK = 12500;
   logic       ref_clk;
   logic       rst_b;
   axes_s      axes;
   reg_wr_s    regWr;
   logic [7:0] regAddr;
   logic [7:0] regRdata;
   logic       intOut;
   logic       fallIrqStatus;
   logic       motionIrqStatus;
   logic [7:0] rv;
   int         fail_count;
   int         checks;
   int         n;
   accel_freefall_motion_detect DUT (.ref_clk(ref_clk), .rst_b(rst_b), .axes(axes), .regWr(regWr),
      .regAddr(regAddr), .regRdata(regRdata), .intOut(intOut), .fallIrqStatus(fallIrqStatus),
      .motionIrqStatus(motionIrqStatus));
   accel_host_model host (.regRdata(regRdata), .ref_clk(ref_clk), .regWr(regWr), .regAddr(regAddr));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic end_sim();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic set_axes(input sample_t x, input sample_t y, input sample_t z);
      @(posedge ref_clk);
      axes <= '{x: x, y: y, z: z};
   endtask
   // A required level that never comes ends the run; an optional one just returns the count.
   task automatic wait_flag(input logic mot, input logic lvl, input int lim, input logic must, output int k);
      k = 0;
      while ((mot ? motionIrqStatus : fallIrqStatus) !== lvl && k < lim) begin
         @(posedge ref_clk);
         k++;
      end
      if (must && k >= lim) begin
         fail_count++;
         $display("ERROR flag wait exp %h got %h", lvl, ~lvl);
         end_sim();
      end
   endtask
   task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rv);
      `CHK("register read", e, rv)
   endtask
   task automatic t_regs();
      check_reg(8'h88, 8'h0e);
      check_reg(8'h89, 8'h01);
      check_reg(8'h8a, 8'h55);
      check_reg(8'h8b, 8'h01);
      check_reg(8'h08, 8'h00);
      check_reg(8'h8f, 8'h00);
      host.wr(7'h09, 8'hff);
      check_reg(8'h89, 8'hff);
      host.wr(7'h0a, 8'ha5);
      check_reg(8'h8a, 8'ha5);
      host.wr(7'h09, 8'h01);
      host.wr(7'h0a, 8'h55);
      host.wr(7'h0b, 8'h00);
      host.wr(7'h0c, 8'h03);
      $display("test regs done");
   endtask
   task automatic t_fall();
      // A zero delay lets one tick settle the at-threshold case, which keeps the run short.
      host.wr(7'h09, 8'h00);
      set_axes(12'h0d0, 12'h0d0, 12'h0e0);
      wait_flag(1'b0, 1'b1, TICK + 10, 1'b0, n);
      `CHK("fall with one axis at threshold", 1'b0, fallIrqStatus)
      host.wr(7'h09, 8'h01);
      set_axes(12'h0d0, 12'h0d0, 12'h0df);
      wait_flag(1'b0, 1'b1, 2 * TICK + 10, 1'b1, n);
      `CHK("fall delay window", 1'b1, n > TICK && n <= 2 * TICK + 10)
      check_reg(8'h8e, 8'h01);
      `CHK("pin on fall", 1'b1, intOut)
      host.wr(7'h0c, 8'h13);
      set_axes(12'h300, 12'h300, 12'h300);
      wait_flag(1'b0, 1'b0, TICK + 10, 1'b0, n);
      `CHK("fall latched", 1'b1, fallIrqStatus)
      host.wr(7'h0e, 8'hfe);
      `CHK("fall cleared", 1'b0, fallIrqStatus)
      set_axes(12'h0d0, 12'h0d0, 12'h0df);
      host.wr(7'h09, 8'h00);
      host.wr(7'h0d, 8'h40);
      wait_flag(1'b0, 1'b1, TICK + 10, 1'b0, n);
      `CHK("fall while disabled", 1'b0, fallIrqStatus)
      set_axes(12'h300, 12'h300, 12'h300);
      host.wr(7'h0d, 8'h42);
      host.wr(7'h0c, 8'h03);
      $display("test fall done");
   endtask
   task automatic t_motion();
      set_axes(12'h300, 12'h560, 12'h300);
      wait_flag(1'b1, 1'b1, TICK + 10, 1'b1, n);
      check_reg(8'h8e, 8'h02);
      `CHK("pin on motion", 1'b1, intOut)
      set_axes(12'h300, 12'h300, 12'h300);
      wait_flag(1'b1, 1'b0, TICK + 10, 1'b1, n);
      $display("test motion done");
   endtask
   initial begin
      fail_count = 0;
      checks     = 0;
      rst_b      = 1'b0;
      axes       = '{x: 12'h300, y: 12'h300, z: 12'h300};
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_regs();
      t_fall();
      t_motion();
      end_sim();
   end
endmodule
bind accel_freefall_motion_detect accel_detect_properties chk (.ref_clk(ref_clk), .rst_b(rst_b), .axes(axes),
   .regWr(regWr), .regAddr(regAddr), .regRdata(regRdata), .intOut(intOut), .fallIrqStatus(fallIrqStatus),
   .motionIrqStatus(motionIrqStatus));
